// File: sshc_defs.vh
// Constants for the steering spool hold control block
`ifndef SSHC_DEFS_VH
`define SSHC_DEFS_VH
// Clock rate and the millisecond tick derived from it
`define SSHC_CLK_HZ 25000000
`define SSHC_MS_NS 1000000
`define SSHC_CLK_NS 40
`define SSHC_MS_CYCLES (`SSHC_MS_NS / `SSHC_CLK_NS)
// Register byte offsets
`define SSHC_A_CTRL 8'h00
`define SSHC_A_HOLD 8'h04
`define SSHC_A_OFFDLY 8'h08
`define SSHC_A_DB 8'h0C
`define SSHC_A_RLIM 8'h10
`define SSHC_A_LLIM 8'h14
`define SSHC_A_SAT 8'h18
`define SSHC_A_CP0 8'h20
`define SSHC_A_CP4 8'h30
`define SSHC_A_STAT 8'h40
`define SSHC_A_POS 8'h44
// Reset values
`define SSHC_HOLD_RST 15'h2710
`define SSHC_OFF_RST 15'h7530
`define SSHC_DB_RST 8'h00
`define SSHC_RLIM_RST 12'sh3E8
`define SSHC_LLIM_RST 12'shC18
`define SSHC_SAT_RST 12'sh3E8
`define SSHC_CP_RST 8'h00
`define SSHC_PROG_RST 3'h0
// Value ranges and codes
`define SSHC_TMO_MIN 15'h0001
`define SSHC_TMO_MAX 15'h7530
`define SSHC_SHORT_LIM 15'h0015
`define SSHC_DB_MAX 8'hFA
`define SSHC_SAT_MIN 12'sh0FB
`define SSHC_POS_MAX 12'sh3E8
`define SSHC_POS_MIN 12'shC18
`define SSHC_PROG_MAX 3'h4
`define SSHC_CP_CLOSED 8'hFF
`define SSHC_VALVE_DB 12'sh064
// Status register bit positions
`define SSHC_ST_BRIDGE 0
`define SSHC_ST_CLOSED 1
`define SSHC_ST_TRACK 2
`define SSHC_ST_HELD 3
`define SSHC_ST_HOLDEXP 4
`define SSHC_ST_OFFEXP 5
`endif

// File: sshc_ms_timer.v
// Millisecond timer that runs while enabled and flags when its limit is reached
module sshc_ms_timer #(
    parameter W = 15
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire tick,
    input wire run,
    input wire [W-1:0] limit,
    output reg expired_q
);
    reg [W-1:0] cnt_q;

    // Count ticks while running; any stop clears both count and flag
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= {W{1'b0}};
            expired_q <= 1'b0;
        end else if (!run) begin
            cnt_q <= {W{1'b0}};
            expired_q <= 1'b0;
        end else begin
            if (tick && (cnt_q < limit))
                cnt_q <= cnt_q + 1'b1;
            expired_q <= (cnt_q >= limit);
        end
    end
endmodule

// File: sshc_steer_hold.v
// Steering spool hold control: spool jump/hold, bridge off-delay, set point, tracking
// Function
// - Hold timeout below 21 ms: spool neutral at once when flow request is zero.
// - Short mode: spool jumps neutral to dead-band side; device dead band unused.
// - Timeout 21..30000 ms bounds dead-band hold time at zero flow request.
// - Hold mode: flow request left or right puts spool on that dead-band side.
// - Hold mode: input inside device dead band moves spool proportionally, within timeout.
// - Zero request for full timeout: spool neutral, dead-band movement ignored.
// - After timeout neutral, a new request jumps straight to its position.
// - Hold timeout defaults to 10000 ms, accepts 1 to 30000 ms.
// - Bridge disabled after off-delay of zero request, enabled otherwise.
// - Off-delay defaults to 30000, range 1..30000; 30000 keeps bridge always on.
// - Bridge re-enabled as soon as a non-zero flow request arrives.
// - Closed-loop start: port flow held zero until deviation reaches or crosses zero.
// - Closed-loop position control selected when program's principle value equals 255.
// - Program digit 0..4 picks one of five programs, used for all its values; here the programs differ only in their principle value.
// - Dead band around input middle gives no steering for small deviations.
// - Right and left limits bound set point; swapping signs reverses direction.
// - Input beyond saturation threshold drives set point to its maximum or minimum.
// - Device dead band ranges 0..250 (0..25.0 percent), default 0.
//
// Chosen here: the register addresses and the APB slave port.
`include "sshc_defs.vh"
module sshc_steer_hold #(
    parameter MS_CYCLES = `SSHC_MS_CYCLES,
    parameter signed [11:0] VALVE_DB = `SSHC_VALVE_DB
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire signed [11:0] flow_request,
    input wire signed [11:0] steer_input,
    input wire signed [11:0] actuator_pos,
    output reg signed [11:0] spool_pos,
    output reg bridge_en,
    output reg signed [11:0] set_point,
    output reg signed [11:0] port_flow_cmd,
    output reg closed_loop,
    output reg tracking
);
    localparam [31:0] MS_SPAN = MS_CYCLES - 1;
    localparam [14:0] MS_LAST = MS_SPAN[14:0]; // Tick divider fits the 15-bit counter

    // Clamp a signed value into [lo, hi]
    function signed [11:0] clamp12;
        input signed [12:0] x;
        input signed [11:0] lo;
        input signed [11:0] hi;
        begin
            if (x < lo)
                clamp12 = lo;
            else if (x > hi)
                clamp12 = hi;
            else
                clamp12 = x[11:0];
        end
    endfunction

    // Clamp a timeout write into its legal millisecond range
    function [14:0] clamp_tmo;
        input [31:0] x;
        begin
            if (x < `SSHC_TMO_MIN)
                clamp_tmo = `SSHC_TMO_MIN;
            else if (x > `SSHC_TMO_MAX)
                clamp_tmo = `SSHC_TMO_MAX;
            else
                clamp_tmo = x[14:0];
        end
    endfunction

    // One side of the set-point curve; mag is the input magnitude, never negative except for the most negative input
    function signed [11:0] curve;
        input signed [11:0] mag;
        input [7:0] db;
        input signed [11:0] sat;
        input signed [11:0] lim;
        reg signed [24:0] num;
        reg signed [12:0] den;
        reg signed [24:0] q;
        begin
            num = lim * (mag - $signed({5'h00, db}));
            den = sat - $signed({5'h00, db});
            q = num / den;
            if (mag <= $signed({5'h00, db}))
                curve = 12'sh000;
            else if (mag >= sat)
                curve = lim;
            else
                curve = q[11:0];
        end
    endfunction

    // Configuration registers
    reg [2:0] prog_q;
    reg [14:0] hold_tmo_q;
    reg [14:0] off_dly_q;
    reg [7:0] db_q;
    reg signed [11:0] rlim_q;
    reg signed [11:0] llim_q;
    reg signed [11:0] sat_q;
    reg [7:0] cp_q [0:4];

    // Internal state
    reg [14:0] ms_cnt_q;
    reg ms_tick_q;
    reg held_q;
    reg dir_right_q;
    reg err_neg_q;
    reg signed [11:0] req_cl_q;
    wire hold_exp;
    wire off_exp;
    wire apb_acc = psel && penable && !pready;
    wire apb_done = psel && penable && pready;
    integer i;

    // Flow request seen by the spool: device input in open loop, controller output closed
    wire signed [11:0] req_raw = closed_loop ? req_cl_q : flow_request;
    wire signed [11:0] req = clamp12({req_raw[11], req_raw}, `SSHC_POS_MIN, `SSHC_POS_MAX);
    wire req_zero = (req == 12'sh000);
    wire short_mode = (hold_tmo_q < `SSHC_SHORT_LIM);
    wire cl_sel = (cp_q[prog_q] == `SSHC_CP_CLOSED);
    wire signed [11:0] db_s = $signed({4'h0, db_q});
    wire signed [11:0] steer_neg = -steer_input;
    wire signed [12:0] track_err = set_point - actuator_pos;

    // Millisecond tick shared by both timers
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ms_cnt_q <= 15'h0000;
            ms_tick_q <= 1'b0;
        end else if (ms_cnt_q == MS_LAST) begin
            ms_cnt_q <= 15'h0000;
            ms_tick_q <= 1'b1;
        end else begin
            ms_cnt_q <= ms_cnt_q + 15'h0001;
            ms_tick_q <= 1'b0;
        end
    end

    // Hold timer runs only while the request is zero; a request restarts it
    sshc_ms_timer #(.W(15)) u_hold_tmr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick(ms_tick_q),
        .run(req_zero),
        .limit(hold_tmo_q),
        .expired_q(hold_exp)
    );

    // Bridge off-delay timer, same restart behaviour
    sshc_ms_timer #(.W(15)) u_off_tmr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick(ms_tick_q),
        .run(req_zero),
        .limit(off_dly_q),
        .expired_q(off_exp)
    );

    // Spool position: jump, dead-band hold with proportional trim, or neutral
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            spool_pos <= 12'sh000;
            held_q <= 1'b0;
            dir_right_q <= 1'b1;
        end else if (!req_zero) begin
            // A new request always lands on its side directly
            held_q <= !short_mode;
            dir_right_q <= !req[11];
            if (req[11])
                spool_pos <= req - VALVE_DB;
            else
                spool_pos <= req + VALVE_DB;
        end else if (short_mode) begin
            spool_pos <= 12'sh000;
            held_q <= 1'b0;
        end else if (held_q && !hold_exp) begin
            // Trim follows the input only while it stays inside the dead band
            if (steer_input <= db_s && steer_input >= -db_s)
                spool_pos <= (dir_right_q ? VALVE_DB : -VALVE_DB) + steer_input;
            else
                spool_pos <= dir_right_q ? VALVE_DB : -VALVE_DB;
        end else begin
            spool_pos <= 12'sh000;
            held_q <= 1'b0;
        end
    end

    // Bridge enable; the maximum delay means the off function is disabled
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            bridge_en <= 1'b1;
        else if (off_dly_q == `SSHC_TMO_MAX)
            bridge_en <= 1'b1;
        else if (!req_zero)
            bridge_en <= 1'b1;
        else
            bridge_en <= !off_exp;
    end

    // Set point from the input angle: dead band, limits, saturation
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            set_point <= 12'sh000;
        else if (steer_input[11])
            set_point <= curve(steer_neg, db_q, sat_q, llim_q);
        else
            set_point <= curve(steer_input, db_q, sat_q, rlim_q);
    end

    // Closed-loop entry and tracking; flow stays zero until deviation hits or crosses zero
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            closed_loop <= 1'b0;
            tracking <= 1'b0;
            err_neg_q <= 1'b0;
            req_cl_q <= 12'sh000;
            port_flow_cmd <= 12'sh000;
        end else begin
            closed_loop <= cl_sel;
            err_neg_q <= track_err[12];
            if (cl_sel && !closed_loop)
                tracking <= 1'b1;
            else if (!cl_sel)
                tracking <= 1'b0;
            else if (track_err == 13'sh0000 || track_err[12] != err_neg_q)
                tracking <= 1'b0;
            if (!cl_sel || tracking || (cl_sel && !closed_loop)) begin
                req_cl_q <= 12'sh000;
                port_flow_cmd <= 12'sh000;
            end else begin
                req_cl_q <= clamp12(track_err, `SSHC_POS_MIN, `SSHC_POS_MAX);
                port_flow_cmd <= clamp12(track_err, `SSHC_POS_MIN, `SSHC_POS_MAX);
            end
        end
    end

    // APB write side; out-of-range values are clamped rather than refused, but CTRL, the CP entries, the limit registers and SAT see only their low pwdata bits
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            prog_q <= `SSHC_PROG_RST;
            hold_tmo_q <= `SSHC_HOLD_RST;
            off_dly_q <= `SSHC_OFF_RST;
            db_q <= `SSHC_DB_RST;
            rlim_q <= `SSHC_RLIM_RST;
            llim_q <= `SSHC_LLIM_RST;
            sat_q <= `SSHC_SAT_RST;
            for (i = 0; i < 5; i = i + 1)
                cp_q[i] <= `SSHC_CP_RST;
        end else if (apb_done && pwrite) begin
            case (paddr)
                `SSHC_A_CTRL: begin
                    if (pwdata[2:0] > `SSHC_PROG_MAX)
                        prog_q <= `SSHC_PROG_MAX;
                    else
                        prog_q <= pwdata[2:0];
                end
                `SSHC_A_HOLD: hold_tmo_q <= clamp_tmo(pwdata);
                `SSHC_A_OFFDLY: off_dly_q <= clamp_tmo(pwdata);
                `SSHC_A_DB: begin
                    if (pwdata > {24'h000000, `SSHC_DB_MAX})
                        db_q <= `SSHC_DB_MAX;
                    else
                        db_q <= pwdata[7:0];
                end
                `SSHC_A_RLIM: rlim_q <= clamp12(pwdata[12:0], `SSHC_POS_MIN, `SSHC_POS_MAX);
                `SSHC_A_LLIM: llim_q <= clamp12(pwdata[12:0], `SSHC_POS_MIN, `SSHC_POS_MAX);
                `SSHC_A_SAT: sat_q <= clamp12(pwdata[12:0], `SSHC_SAT_MIN, `SSHC_POS_MAX);
                default: begin
                    if (paddr >= `SSHC_A_CP0 && paddr <= `SSHC_A_CP4 && paddr[1:0] == 2'h0)
                        cp_q[paddr[4:2]] <= pwdata[7:0];
                end
            endcase
        end
    end

    // Read data and error for the current address
    reg [31:0] rd_d;
    reg err_d;
    always @* begin
        rd_d = 32'h00000000;
        err_d = 1'b0;
        case (paddr)
            `SSHC_A_CTRL: rd_d = {29'h00000000, prog_q};
            `SSHC_A_HOLD: rd_d = {17'h00000, hold_tmo_q};
            `SSHC_A_OFFDLY: rd_d = {17'h00000, off_dly_q};
            `SSHC_A_DB: rd_d = {24'h000000, db_q};
            `SSHC_A_RLIM: rd_d = {{20{rlim_q[11]}}, rlim_q};
            `SSHC_A_LLIM: rd_d = {{20{llim_q[11]}}, llim_q};
            `SSHC_A_SAT: rd_d = {{20{sat_q[11]}}, sat_q};
            `SSHC_A_STAT: begin
                rd_d[`SSHC_ST_BRIDGE] = bridge_en;
                rd_d[`SSHC_ST_CLOSED] = closed_loop;
                rd_d[`SSHC_ST_TRACK] = tracking;
                rd_d[`SSHC_ST_HELD] = held_q;
                rd_d[`SSHC_ST_HOLDEXP] = hold_exp;
                rd_d[`SSHC_ST_OFFEXP] = off_exp;
            end
            `SSHC_A_POS: rd_d = {set_point, 8'h00, spool_pos};
            default: begin
                if (paddr >= `SSHC_A_CP0 && paddr <= `SSHC_A_CP4 && paddr[1:0] == 2'h0)
                    rd_d = {24'h000000, cp_q[paddr[4:2]]};
                else
                    err_d = 1'b1;
            end
        endcase
    end

    // One wait state: pready rises in the second access cycle, all answers registered
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_acc;
            pslverr <= apb_acc && err_d;
            prdata <= (apb_acc && !pwrite) ? rd_d : 32'h00000000;
        end
    end
endmodule

// File: sshc_properties.sv
// Port-level checks for the steering spool hold control block
module sshc_properties (
    input wire clk_sys,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire signed [11:0] flow_request,
    input wire signed [11:0] steer_input,
    input wire signed [11:0] spool_pos,
    input wire bridge_en,
    input wire signed [11:0] set_point,
    input wire signed [11:0] port_flow_cmd,
    input wire closed_loop,
    input wire tracking
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    // Open-loop requests land on the valve dead band plus the request
    a_spool_right: assert property ((!closed_loop && flow_request > 0) |=>
        spool_pos == $past(flow_request) + 12'sh064) else $error("right spool offset wrong");
    a_spool_left: assert property ((!closed_loop && flow_request < 0) |=>
        spool_pos == $past(flow_request) - 12'sh064) else $error("left spool offset wrong");
    a_bridge_wake: assert property ((!closed_loop && flow_request != 0) |=> bridge_en)
        else $error("bridge off under request");
    // Zero request only ever trims inside dead band plus widest device dead band
    a_idle_trim: assert property ((!closed_loop && flow_request == 0) |=>
        spool_pos <= 12'sh15E && spool_pos >= -12'sh15E) else $error("idle spool too far");
    a_center_quiet: assert property (steer_input == 0 |=> set_point == 0)
        else $error("set point moved at centre");
    a_track_hold: assert property (tracking |-> port_flow_cmd == 0)
        else $error("flow while tracking");
    a_track_entry: assert property ($rose(closed_loop) |-> tracking)
        else $error("loop entered without tracking");
    // One wait state, then a single-cycle answer
    a_apb_wait: assert property ((psel && !penable) |=> !pready ##1 pready)
        else $error("bus answer timing wrong");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
endmodule

bind sshc_steer_hold sshc_properties u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .flow_request(flow_request), .steer_input(steer_input), .spool_pos(spool_pos),
    .bridge_en(bridge_en), .set_point(set_point), .port_flow_cmd(port_flow_cmd),
    .closed_loop(closed_loop), .tracking(tracking));

// File: sshc_partner.sv
// Steering cylinder model moved by the closed-loop port flow command
module sshc_partner (
    input wire clk_sys,
    input wire sys_rst,
    input wire slow,
    input wire bridge_en,
    input wire signed [11:0] port_flow_cmd,
    output reg signed [11:0] actuator_pos
);
    timeunit 1ns;
    timeprecision 1ps;
    reg skip_q;
    // One step per cycle; a sluggish cylinder skips every other cycle
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            actuator_pos <= 12'sh0C8;
            skip_q <= 1'b0;
        end else begin
            skip_q <= slow & ~skip_q;
            if (bridge_en && !skip_q && port_flow_cmd != 12'sh000)
                actuator_pos <= actuator_pos + (port_flow_cmd > 0 ? 12'sh001 : -12'sh001);
        end
    end
endmodule

// File: sshc_tb.sv
// Self-checking bench for the steering spool hold control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic signed [11:0] flow_request = 12'sh000;
    logic signed [11:0] steer_input = 12'sh000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, bridge_en, closed_loop, tracking, er;
    logic signed [11:0] spool_pos, set_point, port_flow_cmd, actuator_pos;
    logic [31:0] seed = 32'hB119;
    int err_count = 0;
    int total_checks = 0;
    int i, j, v, n;
    int cdb[3] = '{0, 50, 30};
    int csat[3] = '{1000, 600, 400};
    int crl[3] = '{1000, 800, -900};
    int cll[3] = '{-1000, -700, 900};
    logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] rv[7] = '{32'h0, 32'h2710, 32'h7530, 32'h0, 32'h3E8, 32'hFFFFFC18, 32'h3E8};

    // Clock generator
    always #20 clk_sys = ~clk_sys;

    sshc_steer_hold #(.MS_CYCLES(MS)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flow_request(flow_request),
        .steer_input(steer_input), .actuator_pos(actuator_pos), .spool_pos(spool_pos),
        .bridge_en(bridge_en), .set_point(set_point), .port_flow_cmd(port_flow_cmd),
        .closed_loop(closed_loop), .tracking(tracking));
    sshc_partner partner (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
        .bridge_en(bridge_en), .port_flow_cmd(port_flow_cmd), .actuator_pos(actuator_pos));

    // Comparison with immediate report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Shift register stimulus, symmetric range of +-m
    function automatic int rnd(input int m);
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return int'(seed % 32'(2 * m + 1)) - m;
    endfunction

    function automatic int spool_exp(input int req);
        return req > 0 ? req + 100 : req - 100;
    endfunction

    // Set point: dead band, saturation, then linear share of the limit
    function automatic int sp_exp(input int x, input int db, input int sat, input int rl,
        input int ll);
        int a;
        a = x < 0 ? -x : x;
        if (a <= db) return 0;
        if (x >= sat) return rl;
        if (x <= -sat) return ll;
        return (x > 0 ? rl : ll) * (a - db) / (sat - db);
    endfunction

    // Bus cycle: request held until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(k, 32'h2); // One wait state before the answer
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // Let the design take the new inputs, then look between edges
    task automatic settle;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // Hang guard; a full run needs well under 10000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        wrap_up;
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (i = 0; i < 7; i++) rdchk(ra[i], rv[i]);
        for (i = 0; i < 5; i++) rdchk(8'h20 + 8'(4 * i), 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        chk(er, 1'b1);
        wr(8'h04, 32'h0);
        rdchk(8'h04, 32'h1);
        wr(8'h04, 32'h9C40);
        rdchk(8'h04, 32'h7530);
        wr(8'h0C, 32'h12C);
        rdchk(8'h0C, 32'hFA);
        wr(8'h0C, 32'h0);
        // Closed loop through program 2, tracking until deviation crosses zero
        wr(8'h00, 32'h2);
        wr(8'h28, 32'hFF);
        settle;
        chk(closed_loop, 1'b1);
        chk(tracking, 1'b1);
        repeat (20) @(posedge clk_sys);
        chk(actuator_pos, 32'hC8);
        n = 0;
        while (tracking === 1'b1 && n < 200) begin
            @(posedge clk_sys);
            steer_input <= steer_input + 12'sh00A;
            n++;
        end
        chk(steer_input >= 12'sh0BE, 1'b1);
        slow <= 1'b1;
        steer_input <= 12'sh258;
        n = 0;
        while (actuator_pos !== 12'sh258 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        chk(actuator_pos, 32'h258);
        wr(8'h00, 32'h7);
        rdchk(8'h00, 32'h4);
        chk(closed_loop, 1'b0);
        wr(8'h00, 32'h0);
        // Hold mode: random jumps, then trim, restart and expiry
        wr(8'h04, 32'h1E);
        wr(8'h0C, 32'h32);
        for (i = 0; i < 30; i++) begin
            @(posedge clk_sys);
            v = rnd(999);
            if (v == 0) v = 300;
            flow_request <= 12'(v);
            steer_input <= 12'(rnd(40));
            settle;
            chk(spool_pos, spool_exp(v));
        end
        @(posedge clk_sys);
        flow_request <= 12'sh12C;
        steer_input <= 12'sh014;
        @(posedge clk_sys);
        flow_request <= 12'sh000;
        repeat (20 * MS) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(spool_pos, 32'h78);
        @(posedge clk_sys);
        flow_request <= 12'sh010;
        @(posedge clk_sys);
        flow_request <= 12'sh000;
        repeat (28 * MS) @(posedge clk_sys);
        steer_input <= -12'sh014;
        settle;
        chk(spool_pos, 32'h50);
        repeat (5 * MS) @(posedge clk_sys);
        steer_input <= 12'sh00A;
        settle;
        chk(spool_pos, 32'h0);
        chk(bridge_en, 1'b1);
        @(posedge clk_sys);
        flow_request <= -12'sh0C8;
        settle;
        chk(spool_pos, -32'sd300);
        // Short timeout: neutral at once, no trim
        wr(8'h04, 32'h14);
        @(posedge clk_sys);
        flow_request <= 12'sh190;
        @(posedge clk_sys);
        flow_request <= 12'sh000;
        steer_input <= 12'sh014;
        settle;
        chk(spool_pos, 32'h0);
        @(posedge clk_sys);
        flow_request <= -12'sh005;
        settle;
        chk(spool_pos, -32'sd105);
        // Hold set as an integrator would; bridge off after 5 ms of zero request
        wr(8'h04, 32'h32);
        wr(8'h08, 32'h5);
        @(posedge clk_sys);
        flow_request <= 12'sh000;
        repeat (3 * MS) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(bridge_en, 1'b1);
        repeat (5 * MS) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(bridge_en, 1'b0);
        @(posedge clk_sys);
        flow_request <= 12'sh007;
        settle;
        chk(bridge_en, 1'b1);
        // Set point shaping over three configurations, limits swapped in the last
        for (j = 0; j < 3; j++) begin
            wr(8'h0C, 32'(cdb[j]));
            wr(8'h18, 32'(csat[j]));
            wr(8'h10, 32'(crl[j]));
            wr(8'h14, 32'(cll[j]));
            for (i = 0; i < 12; i++) begin
                @(posedge clk_sys);
                v = i == 0 ? 1000 : i == 1 ? -1000 : i == 2 ? cdb[j] : rnd(1000);
                steer_input <= 12'(v);
                settle;
                chk(set_point, sp_exp(v, cdb[j], csat[j], crl[j], cll[j]));
            end
        end
        // Readback words: spool held at 107, bridge on, held flag set
        rdchk(8'h44, {12'(sp_exp(v, cdb[2], csat[2], crl[2], cll[2])), 8'h00, 12'h06B});
        rdchk(8'h40, 32'h9);
        wrap_up;
    end
endmodule
